// ===== src/ledphy_regs.sv
// indicator and transceiver control registers behind an AXI4-Lite slave
`timescale 1ns/1ps
module ledphy_regs
   import ledphy_pkg::*;
#(
   parameter int CYC0 = BLINK0_CYC,
   parameter int CYC1 = BLINK1_CYC,
   parameter int CYC2 = BLINK2_CYC,
   parameter int CYC3 = BLINK3_CYC
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   // axi4-lite write data
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // axi4-lite write response
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // axi4-lite read address
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   // axi4-lite read data
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // strap pins
   input  wire logic        strap_polarity,
   input  wire logic        strap_auto_xover,
   input  wire logic        strap_mode,
   input  wire logic [4:0]  strap_address,
   // core status
   input  wire logic        link_up,
   input  wire logic        link_100,
   input  wire logic        activity,
   input  wire logic        an_done,
   input  wire logic        an_full_duplex,
   input  wire logic [1:0]  local_advertised_ability,
   input  wire logic [1:0]  partner_advertised_ability,
   // controls to the transceiver and pin
   output logic             link_indicator_pin,
   output logic             auto_xover_en,
   output logic             force_xover,
   output logic             pause_rx_en,
   output logic             pause_tx_en
);

   // ------------------------------------------------------------
   // strap synchroniser and capture
   // ------------------------------------------------------------
   logic [7:0] strap_s1_ff;
   logic [7:0] strap_s2_ff;
   logic [1:0] strap_cnt_ff;
   logic [1:0] nxt_strap_cnt;
   logic       strap_cap;

   always_comb begin
      nxt_strap_cnt = strap_cnt_ff;
      if (strap_cnt_ff != STRAP_WAIT + 2'h1) begin
         nxt_strap_cnt = strap_cnt_ff + 2'h1;
      end
   end

   assign strap_cap = (strap_cnt_ff == STRAP_WAIT);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_s1_ff  <= 8'h00;
         strap_s2_ff  <= 8'h00;
         strap_cnt_ff <= 2'h0;
      end else begin
         strap_s1_ff  <= {strap_address, strap_mode, strap_auto_xover, strap_polarity};
         strap_s2_ff  <= strap_s1_ff;
         strap_cnt_ff <= nxt_strap_cnt;
      end
   end

   // ------------------------------------------------------------
   // bus handshake
   // ------------------------------------------------------------
   logic        aw_got_ff, nxt_aw_got;
   logic [7:0]  awaddr_ff, nxt_awaddr;
   logic        w_got_ff,  nxt_w_got;
   logic [15:0] wdata_ff,  nxt_wdata;
   logic [1:0]  wstrb_ff,  nxt_wstrb;
   logic        awready_ff, nxt_awready;
   logic        wready_ff,  nxt_wready;
   logic        bvalid_ff,  nxt_bvalid;
   logic [1:0]  bresp_ff,   nxt_bresp;
   logic        arready_ff, nxt_arready;
   logic        rvalid_ff,  nxt_rvalid;
   logic [31:0] rdata_ff,   nxt_rdata;
   logic [1:0]  rresp_ff,   nxt_rresp;
   logic        do_wr;
   logic [15:0] ind_rd;
   logic [15:0] xcv_rd;

   assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;

   always_comb begin
      nxt_aw_got = aw_got_ff;
      nxt_awaddr = awaddr_ff;
      nxt_w_got  = w_got_ff;
      nxt_wdata  = wdata_ff;
      nxt_wstrb  = wstrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp  = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata  = rdata_ff;
      nxt_rresp  = rresp_ff;
      if (awvalid && awready_ff) begin
         nxt_aw_got = 1'b1;
         nxt_awaddr = awaddr;
      end
      if (wvalid && wready_ff) begin
         nxt_w_got = 1'b1;
         nxt_wdata = wdata[15:0];
         nxt_wstrb = wstrb[1:0];
      end
      if (do_wr) begin
         nxt_aw_got = 1'b0;
         nxt_w_got  = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp  = (awaddr_ff == IND_CTRL_ADDR || awaddr_ff == XCV_CTRL_ADDR)
                      ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
         nxt_bvalid = 1'b0;
      end
      if (arvalid && arready_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = RESP_OKAY;
         unique case (araddr)
            IND_CTRL_ADDR: nxt_rdata = {16'h0000, ind_rd};
            XCV_CTRL_ADDR: nxt_rdata = {16'h0000, xcv_rd};
            default: begin
               nxt_rdata = 32'h0000_0000;
               nxt_rresp = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_ff && rready) begin
         nxt_rvalid = 1'b0;
      end
      nxt_awready = !nxt_aw_got && !nxt_bvalid;
      nxt_wready  = !nxt_w_got && !nxt_bvalid;
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff  <= 1'b0;
         awaddr_ff  <= 8'h00;
         w_got_ff   <= 1'b0;
         wdata_ff   <= 16'h0000;
         wstrb_ff   <= 2'h0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= 2'h0;
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= 2'h0;
      end else begin
         aw_got_ff  <= nxt_aw_got;
         awaddr_ff  <= nxt_awaddr;
         w_got_ff   <= nxt_w_got;
         wdata_ff   <= nxt_wdata;
         wstrb_ff   <= nxt_wstrb;
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff  <= nxt_rvalid;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
      end
   end

   // ------------------------------------------------------------
   // register file and pause status
   // ------------------------------------------------------------
   logic [15:0] ind_ff,  nxt_ind;
   logic [15:0] xcv_ff,  nxt_xcv;
   logic [4:0]  addr_ff, nxt_addr;
   logic        prx_ff,  nxt_prx;
   logic        ptx_ff,  nxt_ptx;
   logic        lk_ff,   nxt_lk;
   logic [15:0] bmask;
   logic        lp, la, rp, ra;

   assign ind_rd = ind_ff;
   assign xcv_rd = xcv_ff | {2'h0, prx_ff, ptx_ff, lk_ff, 6'h00, addr_ff};
   assign bmask  = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
   assign lp     = local_advertised_ability[0];
   assign la     = local_advertised_ability[1];
   assign rp     = partner_advertised_ability[0];
   assign ra     = partner_advertised_ability[1];

   always_comb begin
      nxt_ind  = ind_ff;
      nxt_xcv  = xcv_ff;
      nxt_addr = addr_ff;
      nxt_lk   = link_100;
      if (do_wr && awaddr_ff == IND_CTRL_ADDR) begin
         nxt_ind = (ind_ff & ~(bmask & IND_RW_MASK)) | (wdata_ff & bmask & IND_RW_MASK);
      end
      if (do_wr && awaddr_ff == XCV_CTRL_ADDR) begin
         nxt_xcv = (xcv_ff & ~(bmask & XCV_RW_MASK)) | (wdata_ff & bmask & XCV_RW_MASK);
      end
      if (strap_cap) begin
         nxt_ind[IND_POL_BIT]   = strap_s2_ff[0];
         nxt_xcv[XCV_AUTO_BIT]  = strap_s2_ff[1];
         nxt_xcv[XCV_MODE_BIT]  = strap_s2_ff[2];
         nxt_addr               = strap_s2_ff[7:3];
      end
      nxt_prx = 1'b0;
      nxt_ptx = 1'b0;
      if (an_done && an_full_duplex) begin
         nxt_prx = (lp && rp) || (lp && la && !rp && ra);
         nxt_ptx = (lp && rp) || (!lp && la && rp && ra);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ind_ff  <= IND_RST;
         xcv_ff  <= XCV_RST;
         addr_ff <= ADDR_RST;
         prx_ff  <= 1'b0;
         ptx_ff  <= 1'b0;
         lk_ff   <= 1'b0;
      end else begin
         ind_ff  <= nxt_ind;
         xcv_ff  <= nxt_xcv;
         addr_ff <= nxt_addr;
         prx_ff  <= nxt_prx;
         ptx_ff  <= nxt_ptx;
         lk_ff   <= nxt_lk;
      end
   end

   // ------------------------------------------------------------
   // indicator
   // ------------------------------------------------------------
   logic pend_ff,  nxt_pend;
   logic phase_ff, nxt_phase;
   logic pin_ff,   nxt_pin;
   logic tick;
   logic lit;
   logic mode;

   assign mode = xcv_ff[XCV_MODE_BIT];

   ledphy_blink #(
      .CYC0 (CYC0),
      .CYC1 (CYC1),
      .CYC2 (CYC2),
      .CYC3 (CYC3)
   ) u_blink (
      .aclk    (aclk),
      .aresetn (aresetn),
      .rate    (ind_ff[IND_RATE_LSB +: 2]),
      .run     (pend_ff),
      .tick    (tick)
   );

   always_comb begin
      nxt_pend  = pend_ff;
      nxt_phase = phase_ff;
      if (pend_ff && tick) begin
         nxt_phase = !phase_ff;
         if (!phase_ff) begin
            nxt_pend = 1'b0;
         end
      end
      // new activity wins over the end of a blink
      if (activity && !mode && link_up) begin
         nxt_pend = 1'b1;
      end
      if (xcv_ff[XCV_BYP_BIT]) begin
         lit = mode ? link_up : (link_up && !activity);
      end else begin
         lit = mode ? link_up : (link_up && phase_ff);
      end
      if (ind_ff[IND_DRIVE_BIT]) begin
         nxt_pin = ind_ff[IND_FORCE_BIT];
      end else begin
         nxt_pin = ind_ff[IND_POL_BIT] ? lit : !lit;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_ff  <= 1'b0;
         phase_ff <= 1'b1;
         pin_ff   <= 1'b1;
      end else begin
         pend_ff  <= nxt_pend;
         phase_ff <= nxt_phase;
         pin_ff   <= nxt_pin;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign awready            = awready_ff;
   assign wready             = wready_ff;
   assign bvalid             = bvalid_ff;
   assign bresp              = bresp_ff;
   assign arready            = arready_ff;
   assign rvalid             = rvalid_ff;
   assign rdata              = rdata_ff;
   assign rresp              = rresp_ff;
   assign link_indicator_pin = pin_ff;
   assign auto_xover_en      = xcv_ff[XCV_AUTO_BIT];
   assign force_xover        = xcv_ff[XCV_FORCE_BIT];
   assign pause_rx_en        = prx_ff;
   assign pause_tx_en        = ptx_ff;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   rate_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(!aresetn) |-> ind_ff[IND_RATE_LSB +: 2] == RATE_RST)
      else $error("blink rate not at reset value");
   pol_strap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      strap_cap |=> ind_ff[IND_POL_BIT] == $past(strap_s2_ff[0]))
      else $error("polarity strap not captured");
   force_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ind_ff[IND_DRIVE_BIT] |=> link_indicator_pin == $past(ind_ff[IND_FORCE_BIT]))
      else $error("forced level not on pin");
   xover_strap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      strap_cap |=> auto_xover_en == $past(strap_s2_ff[1]))
      else $error("crossover strap not captured");
   xover_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
      do_wr && awaddr_ff == XCV_CTRL_ADDR && wstrb_ff[1]
      |=> force_xover == $past(wdata_ff[XCV_FORCE_BIT]))
      else $error("force crossover not written");
   pause_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !(an_done && an_full_duplex) |=> !pause_rx_en && !pause_tx_en)
      else $error("pause set outside full duplex");
   pause_sym_a: assert property (@(posedge aclk) disable iff (!aresetn)
      an_done && an_full_duplex && lp && rp |=> pause_rx_en && pause_tx_en)
      else $error("symmetric pause not resolved");
   bypass_led_a: assert property (@(posedge aclk) disable iff (!aresetn)
      xcv_ff[XCV_BYP_BIT] && !mode && !ind_ff[IND_DRIVE_BIT] && ind_ff[IND_POL_BIT]
      |=> link_indicator_pin == $past(link_up && !activity))
      else $error("bypass not direct");
   mode_link_a: assert property (@(posedge aclk) disable iff (!aresetn)
      mode && !ind_ff[IND_DRIVE_BIT] && ind_ff[IND_POL_BIT]
      |=> link_indicator_pin == $past(link_up))
      else $error("link mode wrong");
   blink_phase_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !(pend_ff && tick) |=> $stable(phase_ff))
      else $error("phase changed without tick");
   addr_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !strap_cap |=> $stable(addr_ff))
      else $error("address changed after capture");

endmodule : ledphy_regs

// ===== src/ledphy_pkg.sv
// constants for the indicator and transceiver control registers
package ledphy_pkg;

   // ------------------------------------------------------------
   // register map (index and byte address)
   // ------------------------------------------------------------
   localparam logic [7:0]  IND_CTRL_IDX  = 8'h18;
   localparam logic [7:0]  XCV_CTRL_IDX  = 8'h19;
   localparam logic [7:0]  IND_CTRL_ADDR = 8'h60;
   localparam logic [7:0]  XCV_CTRL_ADDR = 8'h64;

   // ------------------------------------------------------------
   // indicator_control fields
   // ------------------------------------------------------------
   localparam int          IND_RATE_LSB  = 9;
   localparam int          IND_POL_BIT   = 7;
   localparam int          IND_DRIVE_BIT = 4;
   localparam int          IND_FORCE_BIT = 1;
   localparam logic [1:0]  RATE_RST      = 2'h2;
   localparam logic [15:0] IND_RW_MASK   = 16'h07ff;
   localparam logic [15:0] IND_RST       = 16'h0400;

   // ------------------------------------------------------------
   // transceiver_control fields
   // ------------------------------------------------------------
   localparam int          XCV_AUTO_BIT  = 15;
   localparam int          XCV_FORCE_BIT = 14;
   localparam int          XCV_PRX_BIT   = 13;
   localparam int          XCV_PTX_BIT   = 12;
   localparam int          XCV_LINK_BIT  = 11;
   localparam int          XCV_BYP_BIT   = 7;
   localparam int          XCV_MODE_BIT  = 5;
   localparam logic [15:0] XCV_RW_MASK   = 16'hc0e0;
   localparam logic [15:0] XCV_RST       = 16'h0020;
   localparam logic [4:0]  ADDR_RST      = 5'h01;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int          CLK_HZ        = 40_000_000;
   localparam int          BLINK0_MS     = 50;
   localparam int          BLINK1_MS     = 100;
   localparam int          BLINK2_MS     = 200;
   localparam int          BLINK3_MS     = 500;
   localparam int          BLINK0_CYC    = CLK_HZ / 1000 * BLINK0_MS;
   localparam int          BLINK1_CYC    = CLK_HZ / 1000 * BLINK1_MS;
   localparam int          BLINK2_CYC    = CLK_HZ / 1000 * BLINK2_MS;
   localparam int          BLINK3_CYC    = CLK_HZ / 1000 * BLINK3_MS;
   localparam int          BLINK_W       = 25;
   localparam logic [1:0]  STRAP_WAIT    = 2'h2;

   // ------------------------------------------------------------
   // bus responses
   // ------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : ledphy_pkg

// ===== src/ledphy_blink.sv
// blink phase timer: one tick pulse per on or off phase
`timescale 1ns/1ps
module ledphy_blink
   import ledphy_pkg::*;
#(
   parameter int CYC0 = BLINK0_CYC,
   parameter int CYC1 = BLINK1_CYC,
   parameter int CYC2 = BLINK2_CYC,
   parameter int CYC3 = BLINK3_CYC
) (
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // control
   input  wire logic [1:0] rate,
   input  wire logic       run,
   // phase end
   output logic            tick
);

   logic [BLINK_W-1:0] cnt_ff;
   logic [BLINK_W-1:0] nxt_cnt;
   logic               tick_ff;
   logic               nxt_tick;
   logic [BLINK_W-1:0] limit;

   // ------------------------------------------------------------
   // period counter
   // ------------------------------------------------------------
   always_comb begin
      unique case (rate)
         2'h0: limit = BLINK_W'(CYC0 - 1);
         2'h1: limit = BLINK_W'(CYC1 - 1);
         2'h2: limit = BLINK_W'(CYC2 - 1);
         2'h3: limit = BLINK_W'(CYC3 - 1);
      endcase
      nxt_tick = 1'b0;
      nxt_cnt  = '0;
      if (run) begin
         if (cnt_ff >= limit) begin
            nxt_tick = 1'b1;
         end else begin
            nxt_cnt = cnt_ff + BLINK_W'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff  <= '0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;

endmodule : ledphy_blink

// ===== verif/ledphy_led_model.sv
// led on the link indicator pin: tracks lit state and dark runs
`timescale 1ns/1ps
module ledphy_led_model (
   // clock
   input  wire logic       aclk,
   // pin and board wiring
   input  wire logic       pin,
   input  wire logic       active_high,
   // observation
   output logic            lit,
   output logic [7:0]      dark_len,
   output logic [7:0]      light_ups
);
   logic [7:0] dark_cnt;

   // unknown level on the pin counts as dark
   assign lit = (pin === active_high);

   initial begin
      dark_cnt  = 8'h00;
      dark_len  = 8'h00;
      light_ups = 8'h00;
   end

   always @(posedge aclk) begin
      if (!lit) begin
         dark_cnt <= dark_cnt + 8'h01;
      end else begin
         if (dark_cnt != 8'h00) begin
            dark_len  <= dark_cnt;
            light_ups <= light_ups + 8'h01;
         end
         dark_cnt <= 8'h00;
      end
   end
endmodule : ledphy_led_model

// ===== verif/tb_top.sv
// self-checking bench for the indicator and transceiver control registers
`timescale 1ns/1ps
module tb_top;
   import ledphy_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, loc_ab, par_ab, rsp;
   logic        s_pol, s_auto, s_mode, link_up, link_100, activity, an_done, an_fd;
   logic [4:0]  s_addr;
   logic        pin, auto_en, force_x, p_rx, p_tx, act_high, lit;
   logic [7:0]  dark_len, light_ups, ups0;
   logic [31:0] rd;
   int          fail_count, comparisons, cycles;

   ledphy_regs #(.CYC0(4), .CYC1(6), .CYC2(8), .CYC3(10)) uut (
      .aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .strap_polarity(s_pol), .strap_auto_xover(s_auto), .strap_mode(s_mode),
      .strap_address(s_addr), .link_up(link_up), .link_100(link_100),
      .activity(activity), .an_done(an_done), .an_full_duplex(an_fd),
      .local_advertised_ability(loc_ab), .partner_advertised_ability(par_ab),
      .link_indicator_pin(pin), .auto_xover_en(auto_en), .force_xover(force_x),
      .pause_rx_en(p_rx), .pause_tx_en(p_tx));

   ledphy_led_model led (
      .aclk(aclk), .pin(pin), .active_high(act_high),
      .lit(lit), .dark_len(dark_len), .light_ups(light_ups));

   always #12.5 aclk = ~aclk;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : wait_cyc

   task automatic axw(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= {16'h0000, d};
      wstrb   <= 4'h3;
      bready  <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (!awready);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (!wready);
            wvalid <= 1'b0;
         end
      join
      while (!bvalid) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axr

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      axw(a, d, rsp);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
      wait_cyc(3);
   endtask : wr

   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      axr(a, rd, rsp);
      chk(n, e, rd);
      chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
   endtask : rdc

   function automatic logic [1:0] pres(input logic [1:0] l, input logic [1:0] p);
      pres[1] = (l[0] & p[0]) | (~l[0] & l[1] & p[0] & p[1]);
      pres[0] = (l[0] & p[0]) | (l[0] & l[1] & ~p[0] & p[1]);
   endfunction : pres

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_map;
      rdc("ind reset", IND_CTRL_ADDR, 32'h0000_0480);
      rdc("xcv reset", XCV_CTRL_ADDR, 32'h0000_8033);
      chk("auto pin", 32'h1, {31'h0, auto_en});
      axw(8'h68, 16'hffff, rsp);
      chk("bresp unmapped", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      axr(8'h68, rd, rsp);
      chk("rresp unmapped", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      chk("rdata unmapped", 32'h0, rd);
      $display("done: reset and map");
   endtask : t_reset_map

   task automatic t_rw;
      link_100 <= 1'b1;
      wr(IND_CTRL_ADDR, 16'hffff);
      rdc("ind all ones", IND_CTRL_ADDR, 32'h0000_07ff);
      wr(XCV_CTRL_ADDR, 16'hffff);
      rdc("xcv all ones", XCV_CTRL_ADDR, 32'h0000_c8f3);
      chk("force xover", 32'h1, {31'h0, force_x});
      wr(XCV_CTRL_ADDR, 16'h0000);
      rdc("xcv zero", XCV_CTRL_ADDR, 32'h0000_0813);
      chk("auto off", 32'h0, {31'h0, auto_en});
      chk("force off", 32'h0, {31'h0, force_x});
      $display("done: read write");
   endtask : t_rw

   task automatic t_force;
      link_up <= 1'b0;
      wr(IND_CTRL_ADDR, 16'h0012);
      chk("forced high", 32'h1, {31'h0, pin});
      wr(IND_CTRL_ADDR, 16'h0090);
      chk("forced low", 32'h0, {31'h0, pin});
      $display("done: force");
   endtask : t_force

   task automatic t_pol_mode;
      wr(XCV_CTRL_ADDR, 16'h0020);
      link_up <= 1'b1;
      wr(IND_CTRL_ADDR, 16'h0080);
      chk("link high pol", 32'h1, {31'h0, pin});
      wr(IND_CTRL_ADDR, 16'h0000);
      chk("link low pol", 32'h0, {31'h0, pin});
      link_up <= 1'b0;
      wait_cyc(3);
      chk("nolink low pol", 32'h1, {31'h0, pin});
      link_up <= 1'b1;
      wr(IND_CTRL_ADDR, 16'h0080);
      ups0 = light_ups;
      activity <= 1'b1;
      @(posedge aclk);
      activity <= 1'b0;
      wait_cyc(40);
      chk("mode1 no blink", {24'h0, ups0}, {24'h0, light_ups});
      $display("done: polarity and mode");
   endtask : t_pol_mode

   task automatic t_bypass;
      wr(XCV_CTRL_ADDR, 16'h0080);
      activity <= 1'b1;
      wait_cyc(3);
      chk("bypass active", 32'h0, {31'h0, pin});
      activity <= 1'b0;
      wait_cyc(3);
      chk("bypass idle", 32'h1, {31'h0, pin});
      $display("done: bypass");
   endtask : t_bypass

   task automatic t_blink;
      int cyc[4];
      cyc = '{4, 6, 8, 10};
      wr(XCV_CTRL_ADDR, 16'h0000);
      for (int r = 0; r < 4; r++) begin
         wr(IND_CTRL_ADDR, 16'(r << IND_RATE_LSB) | 16'h0080);
         ups0 = light_ups;
         activity <= 1'b1;
         @(posedge aclk);
         activity <= 1'b0;
         wait_cyc(60);
         chk("blink count", {24'h0, ups0 + 8'h01}, {24'h0, light_ups});
         // dark phase lasts exactly one blink period
         chk("dark phase", 32'(cyc[r]), {24'h0, dark_len});
      end
      $display("done: blink");
   endtask : t_blink

   task automatic t_pause;
      an_done <= 1'b1;
      an_fd   <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         loc_ab <= 2'(i);
         par_ab <= 2'(i >> 2);
         wait_cyc(3);
         chk("pause tx rx", {30'h0, pres(2'(i), 2'(i >> 2))}, {30'h0, p_tx, p_rx});
      end
      an_fd <= 1'b0;
      wait_cyc(3);
      chk("pause half dup", 32'h0, {30'h0, p_tx, p_rx});
      $display("done: pause");
   endtask : t_pause

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      {s_pol, s_auto, s_mode} = 3'h7;
      s_addr = 5'h13;
      {link_up, link_100, activity, an_done, an_fd} = 5'h00;
      loc_ab = 2'h0;
      par_ab = 2'h0;
      act_high = 1'b1;
      fail_count = 0;
      comparisons = 0;
      cycles = 0;
      wait_cyc(20);
      aresetn <= 1'b1;
      wait_cyc(6);
      t_reset_map();
      t_rw();
      t_force();
      t_pol_mode();
      t_bypass();
      t_blink();
      t_pause();
      summarize();
   end
endmodule : tb_top
